// file: core/sccc_pkg.sv
// Constants for the system and module clock control block
package sccc_pkg;
  localparam logic [7:0] ADDR_GATE_A = 8'h63;
  localparam logic [7:0] ADDR_GATE_B = 8'h64;
  localparam logic [7:0] ADDR_GATE_C = 8'h65;
  localparam logic [7:0] ADDR_SYS_SEL = 8'h66;
  localparam logic [7:0] ADDR_I2S_STEP = 8'h67;
  localparam logic [7:0] ADDR_I2S_MOD = 8'h68;
  localparam logic [7:0] ADDR_CODEC_STEP = 8'h6c;
  localparam logic [7:0] ADDR_CODEC_MOD = 8'h6d;
  localparam logic [7:0] ADDR_HS_EXT = 8'h70;
  localparam logic [7:0] ADDR_MIC_SEL = 8'h73;
  localparam logic [7:0] ADDR_STATUS = 8'h74;

  localparam logic [7:0] RST_GATE_A = 8'h83;
  localparam logic [7:0] RST_GATE_B = 8'h00;
  localparam logic [7:0] RST_GATE_C = 8'h30;
  localparam logic [7:0] RST_SYS_SEL = 8'h06;
  localparam logic [7:0] RST_I2S_STEP = 8'h00;
  localparam logic [7:0] RST_I2S_MOD = 8'h02;
  localparam logic [7:0] RST_CODEC_STEP = 8'h01;
  localparam logic [7:0] RST_CODEC_MOD = 8'h02;
  localparam logic [7:0] RST_HS_EXT = 8'h00;
  localparam logic [7:0] RST_MIC_SEL = 8'h00;

  // Writable bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_GATE_B = 8'h9f;
  localparam logic [7:0] MASK_GATE_C = 8'h3f;
  localparam logic [7:0] MASK_HS_EXT = 8'h01;
  localparam logic [7:0] MASK_MIC_SEL = 8'h02;

  // Field positions
  localparam int SYS_DIV_LSB = 0;
  localparam int SYS_DIV_MSB = 4;
  localparam int SYS_SRC_LSB = 5;
  localparam int SYS_SRC_MSB = 6;
  localparam int HS_SEL_BIT = 7;
  localparam int STEP_EN_BIT = 7;
  localparam int STEP_MSB = 6;
  localparam int HS_EXT_BIT = 0;
  localparam int MIC_SEL_BIT = 1;
  localparam int USB_GATE_BIT = 3;
  localparam int SYSTIMER_GATE_BIT = 1;
  localparam int AUDIO_GATE_BIT = 1;

  // Fixed 2/3 ratio used for the 32 MHz and 16 MHz rates
  localparam logic [6:0] TWO_THIRDS_STEP = 7'h02;
  localparam logic [7:0] TWO_THIRDS_MOD = 8'h03;
  localparam logic [4:0] SYS_DIV_MIN = 5'h02;

  typedef enum logic [1:0] {
    SCCC_SYS_RC,
    SCCC_SYS_HS,
    SCCC_SYS_HS_DIV,
    SCCC_SYS_32M
  } sccc_sys_src_t;

  typedef enum logic [1:0] {
    SCCC_HS_48M,
    SCCC_HS_RC,
    SCCC_HS_XTAL
  } sccc_hs_src_t;
endpackage : sccc_pkg

// file: core/sccc_frac_div.sv
// Step/mod fractional rate divider working on tick enables
`timescale 1ns/10ps
module sccc_frac_div #(
  parameter int STEP_W = 7,
  parameter int MOD_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Rate control
  input wire logic enable,
  input wire logic [STEP_W-1:0] step,
  input wire logic [MOD_W-1:0] modulus,
  // Ticks
  input wire logic in_tick,
  output logic out_tick
);
  logic [MOD_W:0] acc;
  logic [MOD_W:0] sum;

  initial
  begin
    if (STEP_W < 1 || MOD_W <= STEP_W)
      $error("sccc_frac_div: MOD_W must exceed STEP_W");
  end

  assign sum = acc + {{(MOD_W+1-STEP_W){1'b0}}, step};

  // Accumulate step each input tick, emit a tick on each mod wrap
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc <= '0;
      out_tick <= 1'b0;
    end
    else if (!enable || modulus == '0)
    begin
      acc <= '0;
      out_tick <= 1'b0;
    end
    else if (in_tick)
    begin
      if (sum >= {1'b0, modulus})
      begin
        acc <= sum - {1'b0, modulus};
        out_tick <= 1'b1;
      end
      else
      begin
        acc <= sum;
        out_tick <= 1'b0;
      end
    end
    else
      out_tick <= 1'b0;
  end
endmodule : sccc_frac_div

// file: core/sccc_clock_ctrl.sv
// System clock selection, module clock gating and audio rate dividers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
// Function
// - Two-bit source field picks RC, high-speed, divided high-speed or 32 MHz.
// - Divided source gives high-speed rate over the five-bit divider value.
// - High-speed source from ext bit and top select bit: 48M, RC, crystal.
// - 32 MHz option is the 48 MHz clock through a 2/3 divider.
// - 48 MHz clock is the 24 MHz crystal clock doubled.
// - Gate register A enables SPI..debug clocks per bit, reset 0x83.
// - Gate register B gates baseband, timer, DMA, algorithm, AES, key engine.
// - Gate register C gates analog, audio, FIFO, RNG, codec filters, reset 0x30.
// - System timer clock is crystal through 2/3, fixed 16 MHz.
// - USB logic receives the doubled 48 MHz clock.
// - I2S clock runs only while its enable bit is set.
// - I2S clock is 48 MHz times step over mod.
// - Codec clock runs only while its enable bit is set.
// - Codec clock is 48 MHz times step over mod.
// - Microphone clock out from 32 kHz when select bit set, else interface clock.
module sccc_clock_ctrl #(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Source ticks, one mclk pulse per source period, spaced two cycles or more
  input wire logic xtal_tick,
  input wire logic rc_tick,
  input wire logic slow_32k_tick,
  input wire logic mic_if_tick,
  // Derived clock ticks
  output logic sys_tick,
  output logic usb_tick,
  output logic systimer_tick,
  output logic i2s_tick,
  output logic codec_tick,
  output logic mic_clk_tick,
  // Module clock enables
  output logic [7:0] module_clk_en_a,
  output logic [7:0] module_clk_en_b,
  output logic [7:0] module_clk_en_c
);
  logic [7:0] module_clock_gate_a;
  logic [7:0] module_clock_gate_b;
  logic [7:0] module_clock_gate_c;
  logic [7:0] system_clock_source_divider;
  logic [7:0] i2s_clock_enable_step;
  logic [7:0] i2s_clock_mod;
  logic [7:0] codec_clock_enable_step;
  logic [7:0] codec_clock_mod;
  logic [7:0] high_speed_source_ext;
  logic [7:0] mic_clock_output_select;

  logic xtal_tick_q;
  logic pll_tick;
  logic pll32_tick;
  logic st16_tick;
  logic i2s_raw;
  logic codec_raw;
  sccc_pkg::sccc_hs_src_t hs_req;
  sccc_pkg::sccc_hs_src_t hs_active;
  sccc_pkg::sccc_sys_src_t sys_req;
  sccc_pkg::sccc_sys_src_t sys_active;
  logic high_speed_clock;
  logic hs_div_tick;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] div_active;
  logic [DIV_W-1:0] div_req;
  logic next_sys_tick;

  initial
  begin
    if (DIV_W != sccc_pkg::SYS_DIV_MSB - sccc_pkg::SYS_DIV_LSB + 1)
      $error("sccc_clock_ctrl: DIV_W must match the divider field");
  end

  // Tick of a high-speed source candidate
  function automatic logic hs_src_tick(input sccc_pkg::sccc_hs_src_t s,
                                       input logic t48, input logic trc,
                                       input logic txtal);
    case (s)
      sccc_pkg::SCCC_HS_48M: hs_src_tick = t48;
      sccc_pkg::SCCC_HS_RC: hs_src_tick = trc;
      default: hs_src_tick = txtal;
    endcase
  endfunction : hs_src_tick

  // Tick of a system source candidate
  function automatic logic sys_src_tick(input sccc_pkg::sccc_sys_src_t s,
                                        input logic trc, input logic ths,
                                        input logic tdiv, input logic t32);
    case (s)
      sccc_pkg::SCCC_SYS_RC: sys_src_tick = trc;
      sccc_pkg::SCCC_SYS_HS: sys_src_tick = ths;
      sccc_pkg::SCCC_SYS_HS_DIV: sys_src_tick = tdiv;
      default: sys_src_tick = t32;
    endcase
  endfunction : sys_src_tick

  // Register writes
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      module_clock_gate_a <= sccc_pkg::RST_GATE_A;
      module_clock_gate_b <= sccc_pkg::RST_GATE_B;
      module_clock_gate_c <= sccc_pkg::RST_GATE_C;
      system_clock_source_divider <= sccc_pkg::RST_SYS_SEL;
      i2s_clock_enable_step <= sccc_pkg::RST_I2S_STEP;
      i2s_clock_mod <= sccc_pkg::RST_I2S_MOD;
      codec_clock_enable_step <= sccc_pkg::RST_CODEC_STEP;
      codec_clock_mod <= sccc_pkg::RST_CODEC_MOD;
      high_speed_source_ext <= sccc_pkg::RST_HS_EXT;
      mic_clock_output_select <= sccc_pkg::RST_MIC_SEL;
    end
    else if (reg_write)
    begin
      if (reg_addr == sccc_pkg::ADDR_GATE_A)
        module_clock_gate_a <= reg_wdata;
      else if (reg_addr == sccc_pkg::ADDR_GATE_B)
        module_clock_gate_b <= reg_wdata & sccc_pkg::MASK_GATE_B;
      else if (reg_addr == sccc_pkg::ADDR_GATE_C)
        module_clock_gate_c <= reg_wdata & sccc_pkg::MASK_GATE_C;
      else if (reg_addr == sccc_pkg::ADDR_SYS_SEL)
        system_clock_source_divider <= reg_wdata;
      else if (reg_addr == sccc_pkg::ADDR_I2S_STEP)
        i2s_clock_enable_step <= reg_wdata;
      else if (reg_addr == sccc_pkg::ADDR_I2S_MOD)
        i2s_clock_mod <= reg_wdata;
      else if (reg_addr == sccc_pkg::ADDR_CODEC_STEP)
        codec_clock_enable_step <= reg_wdata;
      else if (reg_addr == sccc_pkg::ADDR_CODEC_MOD)
        codec_clock_mod <= reg_wdata;
      else if (reg_addr == sccc_pkg::ADDR_HS_EXT)
        high_speed_source_ext <= reg_wdata & sccc_pkg::MASK_HS_EXT;
      else if (reg_addr == sccc_pkg::ADDR_MIC_SEL)
        mic_clock_output_select <= reg_wdata & sccc_pkg::MASK_MIC_SEL;
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      if (reg_addr == sccc_pkg::ADDR_GATE_A)
        reg_rdata <= module_clock_gate_a;
      else if (reg_addr == sccc_pkg::ADDR_GATE_B)
        reg_rdata <= module_clock_gate_b;
      else if (reg_addr == sccc_pkg::ADDR_GATE_C)
        reg_rdata <= module_clock_gate_c;
      else if (reg_addr == sccc_pkg::ADDR_SYS_SEL)
        reg_rdata <= system_clock_source_divider;
      else if (reg_addr == sccc_pkg::ADDR_I2S_STEP)
        reg_rdata <= i2s_clock_enable_step;
      else if (reg_addr == sccc_pkg::ADDR_I2S_MOD)
        reg_rdata <= i2s_clock_mod;
      else if (reg_addr == sccc_pkg::ADDR_CODEC_STEP)
        reg_rdata <= codec_clock_enable_step;
      else if (reg_addr == sccc_pkg::ADDR_CODEC_MOD)
        reg_rdata <= codec_clock_mod;
      else if (reg_addr == sccc_pkg::ADDR_HS_EXT)
        reg_rdata <= high_speed_source_ext;
      else if (reg_addr == sccc_pkg::ADDR_MIC_SEL)
        reg_rdata <= mic_clock_output_select;
      else if (reg_addr == sccc_pkg::ADDR_STATUS)
        reg_rdata <= {4'h0, 2'(hs_active), 2'(sys_active)};
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end

  // Doubler: two 48M ticks per crystal tick
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      xtal_tick_q <= 1'b0;
    else
      xtal_tick_q <= xtal_tick;
  end

  assign pll_tick = xtal_tick | xtal_tick_q;

  sccc_frac_div #(.STEP_W(7), .MOD_W(8)) u_div32 (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(1'b1),
    .step(sccc_pkg::TWO_THIRDS_STEP),
    .modulus(sccc_pkg::TWO_THIRDS_MOD),
    .in_tick(pll_tick),
    .out_tick(pll32_tick)
  );

  sccc_frac_div #(.STEP_W(7), .MOD_W(8)) u_div16 (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(1'b1),
    .step(sccc_pkg::TWO_THIRDS_STEP),
    .modulus(sccc_pkg::TWO_THIRDS_MOD),
    .in_tick(xtal_tick),
    .out_tick(st16_tick)
  );

  // Mod below twice the step is not checked; the rate is then undefined
  sccc_frac_div #(.STEP_W(7), .MOD_W(8)) u_div_i2s (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(i2s_clock_enable_step[sccc_pkg::STEP_EN_BIT]),
    .step(i2s_clock_enable_step[sccc_pkg::STEP_MSB:0]),
    .modulus(i2s_clock_mod),
    .in_tick(pll_tick),
    .out_tick(i2s_raw)
  );

  sccc_frac_div #(.STEP_W(7), .MOD_W(8)) u_div_codec (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(codec_clock_enable_step[sccc_pkg::STEP_EN_BIT]),
    .step(codec_clock_enable_step[sccc_pkg::STEP_MSB:0]),
    .modulus(codec_clock_mod),
    .in_tick(pll_tick),
    .out_tick(codec_raw)
  );

  // Requested sources
  always_comb
  begin
    if (high_speed_source_ext[sccc_pkg::HS_EXT_BIT])
      hs_req = sccc_pkg::SCCC_HS_XTAL;
    else if (system_clock_source_divider[sccc_pkg::HS_SEL_BIT])
      hs_req = sccc_pkg::SCCC_HS_RC;
    else
      hs_req = sccc_pkg::SCCC_HS_48M;
    sys_req = sccc_pkg::sccc_sys_src_t'(
      system_clock_source_divider[sccc_pkg::SYS_SRC_MSB:sccc_pkg::SYS_SRC_LSB]);
    div_req = system_clock_source_divider[sccc_pkg::SYS_DIV_MSB:sccc_pkg::SYS_DIV_LSB];
  end

  // Switch only in a cycle where neither old nor new source ticks
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      hs_active <= sccc_pkg::SCCC_HS_48M;
    else if (hs_req != hs_active
             && !hs_src_tick(hs_active, pll_tick, rc_tick, xtal_tick)
             && !hs_src_tick(hs_req, pll_tick, rc_tick, xtal_tick))
      hs_active <= hs_req;
  end

  assign high_speed_clock = hs_src_tick(hs_active, pll_tick, rc_tick, xtal_tick);

  // Divided high-speed clock; new divisor taken only at a period end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_cnt <= DIV_W'(1);
      div_active <= sccc_pkg::SYS_DIV_MIN;
      hs_div_tick <= 1'b0;
    end
    else if (high_speed_clock)
    begin
      if (div_cnt >= div_active)
      begin
        div_cnt <= DIV_W'(1);
        hs_div_tick <= 1'b1;
        // Values 0 and 1 are not to be written; clamp keeps the divider sane
        div_active <= (div_req < sccc_pkg::SYS_DIV_MIN) ? sccc_pkg::SYS_DIV_MIN
                                                        : div_req;
      end
      else
      begin
        div_cnt <= div_cnt + DIV_W'(1);
        hs_div_tick <= 1'b0;
      end
    end
    else
      hs_div_tick <= 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sys_active <= sccc_pkg::SCCC_SYS_HS_DIV;
    else if (sys_req != sys_active
             && !sys_src_tick(sys_active, rc_tick, high_speed_clock, hs_div_tick, pll32_tick)
             && !sys_src_tick(sys_req, rc_tick, high_speed_clock, hs_div_tick, pll32_tick))
      sys_active <= sys_req;
  end

  assign next_sys_tick = sys_src_tick(sys_active, rc_tick, high_speed_clock,
                                      hs_div_tick, pll32_tick);

  // Registered clock ticks
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sys_tick <= 1'b0;
      usb_tick <= 1'b0;
      systimer_tick <= 1'b0;
      i2s_tick <= 1'b0;
      codec_tick <= 1'b0;
      mic_clk_tick <= 1'b0;
    end
    else
    begin
      sys_tick <= next_sys_tick;
      usb_tick <= pll_tick & module_clock_gate_a[sccc_pkg::USB_GATE_BIT];
      systimer_tick <= st16_tick & module_clock_gate_b[sccc_pkg::SYSTIMER_GATE_BIT];
      i2s_tick <= i2s_raw & module_clock_gate_c[sccc_pkg::AUDIO_GATE_BIT];
      codec_tick <= codec_raw & module_clock_gate_c[sccc_pkg::AUDIO_GATE_BIT];
      mic_clk_tick <= mic_clock_output_select[sccc_pkg::MIC_SEL_BIT] ? slow_32k_tick
                                                                    : mic_if_tick;
    end
  end

  // Per-module gated system ticks
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      module_clk_en_a <= 8'h00;
      module_clk_en_b <= 8'h00;
      module_clk_en_c <= 8'h00;
    end
    else
    begin
      module_clk_en_a <= module_clock_gate_a & {8{next_sys_tick}};
      module_clk_en_b <= module_clock_gate_b & {8{next_sys_tick}};
      module_clk_en_c <= module_clock_gate_c & {8{next_sys_tick}};
    end
  end
endmodule : sccc_clock_ctrl

// file: sim/sccc_clock_ctrl_monitor.sv
// Port-level assertions for the clock control block
`timescale 1ns/10ps
module sccc_clock_ctrl_monitor #(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Source ticks
  input wire logic xtal_tick,
  input wire logic rc_tick,
  input wire logic slow_32k_tick,
  input wire logic mic_if_tick,
  // Derived ticks
  input wire logic sys_tick,
  input wire logic usb_tick,
  input wire logic systimer_tick,
  input wire logic i2s_tick,
  input wire logic codec_tick,
  input wire logic mic_clk_tick,
  // Module enables
  input wire logic [7:0] module_clk_en_a,
  input wire logic [7:0] module_clk_en_b,
  input wire logic [7:0] module_clk_en_c
);
  logic [7:0] sh_a;
  logic sh_b1;
  logic sh_c1;
  logic sh_i2s;
  logic sh_cod;
  logic sh_mic;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Shadow copies of the control bits
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sh_a <= sccc_pkg::RST_GATE_A;
      sh_b1 <= 1'b0;
      sh_c1 <= 1'b0;
      sh_i2s <= 1'b0;
      sh_cod <= 1'b0;
      sh_mic <= 1'b0;
    end
    else if (reg_write)
    begin
      if (reg_addr == sccc_pkg::ADDR_GATE_A)
        sh_a <= reg_wdata;
      if (reg_addr == sccc_pkg::ADDR_GATE_B)
        sh_b1 <= reg_wdata[1];
      if (reg_addr == sccc_pkg::ADDR_GATE_C)
        sh_c1 <= reg_wdata[1];
      if (reg_addr == sccc_pkg::ADDR_I2S_STEP)
        sh_i2s <= reg_wdata[7];
      if (reg_addr == sccc_pkg::ADDR_CODEC_STEP)
        sh_cod <= reg_wdata[7];
      if (reg_addr == sccc_pkg::ADDR_MIC_SEL)
        sh_mic <= reg_wdata[1];
    end
  end

  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_read_gate_a: assert property ($past(reg_read) && $past(reg_addr) == 8'h63
    |-> reg_rdata == $past(sh_a)) else $error("gate a readback wrong");
  a_en_a_follows: assert property (module_clk_en_a == ($past(sh_a) & {8{sys_tick}}))
    else $error("gate a enables wrong");
  a_en_b_rsvd: assert property (module_clk_en_b[6:5] == 2'b00)
    else $error("gate b reserved enable");
  a_en_c_rsvd: assert property (module_clk_en_c[7:6] == 2'b00)
    else $error("gate c reserved enable");
  a_usb_pair: assert property (xtal_tick && sh_a[3] |-> ##1 (usb_tick || !sh_a[3])
    ##1 (usb_tick || !sh_a[3])) else $error("usb pair missing");
  a_usb_off: assert property (!sh_a[3] [*3] |-> !usb_tick)
    else $error("usb tick while gated");
  a_timer_off: assert property (!sh_b1 [*3] |-> !systimer_tick)
    else $error("timer tick while gated");
  a_i2s_off: assert property (!(sh_i2s && sh_c1) [*3] |-> !i2s_tick)
    else $error("i2s tick while off");
  a_codec_off: assert property (!(sh_cod && sh_c1) [*3] |-> !codec_tick)
    else $error("codec tick while off");
  a_mic_slow: assert property (slow_32k_tick && sh_mic && $past(sh_mic)
    |=> mic_clk_tick) else $error("mic tick from slow clock missing");
  a_mic_if: assert property (mic_if_tick && !sh_mic && !$past(sh_mic)
    |=> mic_clk_tick) else $error("mic tick from interface missing");
endmodule : sccc_clock_ctrl_monitor

bind sccc_clock_ctrl sccc_clock_ctrl_monitor #(.DIV_W(DIV_W)) i_sccc_clock_ctrl_monitor (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .xtal_tick(xtal_tick), .rc_tick(rc_tick), .slow_32k_tick(slow_32k_tick),
  .mic_if_tick(mic_if_tick), .sys_tick(sys_tick), .usb_tick(usb_tick),
  .systimer_tick(systimer_tick), .i2s_tick(i2s_tick), .codec_tick(codec_tick),
  .mic_clk_tick(mic_clk_tick), .module_clk_en_a(module_clk_en_a),
  .module_clk_en_b(module_clk_en_b), .module_clk_en_c(module_clk_en_c)
);

// file: sim/tb.sv
// Self-checking testbench for the clock control block
`timescale 1ns/10ps
module tb;
  localparam int W = 300;
  localparam int N_XT = W / 3;
  localparam int N_48 = 2 * N_XT;
  localparam int N_RC = W / 4;
  logic mclk;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic xtal_tick = 1'b0;
  logic rc_tick = 1'b0;
  logic slow_32k_tick = 1'b0;
  logic mic_if_tick = 1'b0;
  wire [5:0] tk;
  logic [7:0] en_a;
  logic [7:0] en_b;
  logic [7:0] en_c;
  int cnt [6];
  int cyc = 0;
  int n_fail = 0;
  int total_checks = 0;

  sccc_clock_ctrl #(.DIV_W(5)) i_sccc_clock_ctrl (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .xtal_tick(xtal_tick), .rc_tick(rc_tick), .slow_32k_tick(slow_32k_tick),
    .mic_if_tick(mic_if_tick), .sys_tick(tk[0]), .usb_tick(tk[1]),
    .systimer_tick(tk[2]), .i2s_tick(tk[3]), .codec_tick(tk[4]), .mic_clk_tick(tk[5]),
    .module_clk_en_a(en_a), .module_clk_en_b(en_b), .module_clk_en_c(en_c)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Free-running source ticks and output pulse counters
  always @(posedge mclk)
  begin
    xtal_tick <= (cyc % 3 == 0);
    rc_tick <= (cyc % 4 == 1);
    slow_32k_tick <= (cyc % 7 == 2);
    mic_if_tick <= (cyc % 5 == 3);
    cyc = cyc + 1;
    for (int i = 0; i < 6; i++)
      if (tk[i] === 1'b1)
        cnt[i] = cnt[i] + 1;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask : rd

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : check8

  // Pulse count over a window, with slack for window edges
  task automatic rate(input int idx, input int exp, input string name);
    int s;
    repeat (30) @(posedge mclk);
    s = cnt[idx];
    repeat (W) @(posedge mclk);
    total_checks++;
    if (cnt[idx] - s < exp - 2 || cnt[idx] - s > exp + 2)
    begin
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, cnt[idx] - s);
      n_fail++;
    end
  endtask : rate

  logic [7:0] adr [10] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6c, 8'h6d,
    8'h70, 8'h73};
  logic [7:0] rst [10] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02,
    8'h00, 8'h00};
  logic [7:0] msk [10] = '{8'hff, 8'h9f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h01, 8'h02};
  // Step registers get step 1 so that each mod stays at least twice its step
  logic [7:0] wv [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h81, 8'hff, 8'h81, 8'hff,
    8'hff, 8'hff};

  task automatic t_registers;
    logic [7:0] d;
    for (int i = 0; i < 10; i++)
    begin
      rd(adr[i], d);
      check8("reset value", rst[i], d);
    end
    for (int i = 0; i < 10; i++)
    begin
      wr(adr[i], wv[i]);
      rd(adr[i], d);
      check8("write readback", wv[i] & msk[i], d);
      wr(adr[i], rst[i]);
    end
    wr(8'h69, 8'h5a);
    rd(8'h69, d);
    check8("unmapped read", 8'h00, d);
    $display("test registers done");
  endtask : t_registers

  task automatic t_gating;
    wr(8'h63, 8'h8b);
    rate(1, N_48, "usb ticks");
    wr(8'h63, 8'h83);
    rate(1, 0, "usb gated");
    wr(8'h64, 8'h02);
    rate(2, N_XT * 2 / 3, "timer ticks");
    wr(8'h64, 8'h00);
    rate(2, 0, "timer gated");
    $display("test gating done");
  endtask : t_gating

  task automatic t_sys_source;
    logic [7:0] ext [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] sel [8] = '{8'h06, 8'h22, 8'ha2, 8'h22, 8'ha2, 8'h44, 8'h5f, 8'h62};
    int exp [8];
    exp = '{N_RC, N_48, N_RC, N_XT, N_XT, N_48 / 4, N_48 / 31, N_48 * 2 / 3};
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h70, ext[i]);
      wr(8'h66, sel[i]);
      rate(0, exp[i], "system ticks");
    end
    wr(8'h70, 8'h00);
    wr(8'h66, 8'h06);
    $display("test system source done");
  endtask : t_sys_source

  task automatic t_audio;
    wr(8'h65, 8'h32);
    wr(8'h68, 8'h04);
    wr(8'h67, 8'h81);
    rate(3, N_48 / 4, "i2s ticks");
    wr(8'h67, 8'h01);
    rate(3, 0, "i2s off");
    wr(8'h6d, 8'h08);
    wr(8'h6c, 8'h83);
    rate(4, N_48 * 3 / 8, "codec ticks");
    wr(8'h6c, 8'h03);
    rate(4, 0, "codec off");
    $display("test audio done");
  endtask : t_audio

  task automatic t_mic;
    wr(8'h73, 8'h02);
    rate(5, W / 7, "mic from slow clock");
    wr(8'h73, 8'h00);
    rate(5, W / 5, "mic from interface");
    $display("test mic done");
  endtask : t_mic

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_registers();
    t_gating();
    t_sys_source();
    t_audio();
    t_mic();
    conclude();
  end

  initial
  begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end
endmodule : tb
